/* hdl/crp_top.sv */
// system pin front end: bus phase clock, reset pin, interrupt requests
`timescale 1ns/10ps
`include "crp_map.svh"
// Function
// [RL1] bus clock is oscillator divided by four
// [RL2] low phase internal, high phase data access
// [RL3] bus clock stops in halt mode
// [RL4] low reset pin initializes device
// [RL5] open-drain reset low on monitor/watchdog failure
// [RL6] accept asynchronous active-low maskable request
// [RL7] software selects falling edge or low level
// [RL8] every reset selects level sensing
// [RL9] nonmaskable request usable after reset completes
// [RL10] reset sets mask; ignored until cleared
// [RL11] nonmaskable request is level sensitive
// [RL12] expanded mode reassigns eighteen bus pins
// [RL13] both requests synchronized before detection
module crp_top
  import crp_pkg::*;
#(
  parameter int DIV = `CRP_CLK_DIV
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       osc_clock_in,
  output logic            osc_drive_out,
  output logic            bus_clk,
  output logic            data_phase,
  output logic            internal_phase,
  input  wire logic       halt_req,
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  output logic            core_reset_n,
  input  wire logic       clk_monitor_fail,
  input  wire logic       watchdog_timer_fail,
  input  wire logic       int_req_n,
  input  wire logic       edge_sel_wr,
  input  wire logic       edge_sel_data,
  output logic            edge_sel,
  output logic            int_pending,
  input  wire logic       int_ack,
  input  wire logic       nonmaskable_int_req_n,
  input  wire logic       nmi_mask_clear,
  output logic            nmi_mask,
  output logic            nmi_pending,
  input  wire logic [1:0] mode_straps,
  output logic            expanded_bus,
  output logic [4:0]      bus_pin_count
);
  // ==========================================================
  // input synchronisers
  logic [5:0] raw_in;
  logic [5:0] sync_in;
  logic       osc_s;
  logic       reset_pin_s;
  logic       irq_s;
  logic       nmi_s;
  logic [1:0] mode_s;

  assign raw_in = {mode_straps, osc_clock_in, reset_pin_in,
                   int_req_n, nonmaskable_int_req_n};

  crp_sync #(.WIDTH(6)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (sync_in)
  ); // RL13

  assign osc_s       = sync_in[3];
  assign reset_pin_s = sync_in[2];
  assign irq_s       = sync_in[1];
  assign nmi_s       = sync_in[0];
  assign mode_s      = sync_in[5:4];

  // ==========================================================
  // oscillator edge detect and divide by four
  logic                      osc_d;
  logic                      osc_rise;
  logic [`CRP_CLK_DIV_W-1:0] phase;

  assign osc_rise = osc_s & ~osc_d;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_d         <= 1'b1;
      osc_drive_out <= 1'b1;
    end else begin
      osc_d         <= osc_s;
      osc_drive_out <= ~osc_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (osc_rise && !halt_req) begin
      phase <= phase + 1'b1; // RL1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_clk        <= 1'b0;
      data_phase     <= 1'b0;
      internal_phase <= 1'b1;
    end else if (halt_req) begin
      bus_clk        <= 1'b0; // RL3
      data_phase     <= 1'b0;
      internal_phase <= 1'b1;
    end else if (osc_rise) begin
      if (phase == `CRP_PH_RISE) begin
        bus_clk        <= 1'b1; // RL1
        data_phase     <= 1'b1; // RL2
        internal_phase <= 1'b0;
      end else if (phase == `CRP_PH_FALL) begin
        bus_clk        <= 1'b0;
        data_phase     <= 1'b0; // RL2
        internal_phase <= 1'b1;
      end
    end
  end

  // ==========================================================
  // reset pin: input and open-drain failure output
  crp_rst_state_t rst_state;
  logic [3:0]     stretch;
  logic           fail;

  assign fail = clk_monitor_fail | watchdog_timer_fail;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rst_state     <= CRP_RST_IDLE;
      stretch       <= 4'h0;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b0;
    end else begin
      case (rst_state)
        CRP_RST_IDLE: begin
          if (fail) begin
            rst_state    <= CRP_RST_DRIVE;
            stretch      <= `CRP_RST_STRETCH;
            reset_pin_oe <= 1'b1; // RL5
          end
        end
        CRP_RST_DRIVE: begin
          if (stretch != 4'h0) begin
            stretch <= stretch - 4'h1;
          end else if (!fail) begin
            rst_state    <= CRP_RST_RELEASE;
            reset_pin_oe <= 1'b0;
          end
        end
        CRP_RST_RELEASE: begin
          if (fail) begin
            rst_state    <= CRP_RST_DRIVE;
            stretch      <= `CRP_RST_STRETCH;
            reset_pin_oe <= 1'b1; // RL5
          end else if (reset_pin_s) begin
            rst_state <= CRP_RST_IDLE;
          end
        end
        default: begin
          rst_state <= CRP_RST_IDLE;
        end
      endcase
    end
  end

  logic in_reset;
  assign in_reset = ~reset_pin_s | reset_pin_oe;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= ~in_reset; // RL4
    end
  end

  // ==========================================================
  // maskable request: edge or level
  logic irq_d;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      edge_sel <= 1'b0;
    end else if (in_reset) begin
      edge_sel <= 1'b0; // RL8
    end else if (edge_sel_wr) begin
      edge_sel <= edge_sel_data; // RL7
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_d       <= 1'b1;
      int_pending <= 1'b0;
    end else begin
      irq_d <= irq_s;
      if (in_reset) begin
        int_pending <= 1'b0;
      end else if (!edge_sel) begin
        int_pending <= ~irq_s; // RL6
      end else if (irq_d && !irq_s) begin
        int_pending <= 1'b1; // RL7
      end else if (int_ack) begin
        int_pending <= 1'b0;
      end
    end
  end

  // ==========================================================
  // nonmaskable request: level, masked from reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nmi_mask <= 1'b1;
    end else if (in_reset) begin
      nmi_mask <= 1'b1; // RL10
    end else if (nmi_mask_clear) begin
      nmi_mask <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nmi_pending <= 1'b0;
    end else begin
      nmi_pending <= ~nmi_s & ~nmi_mask & ~in_reset; // RL9 RL11
    end
  end

  // ==========================================================
  // operating mode strap and bus pin reassignment
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      expanded_bus  <= 1'b0;
      bus_pin_count <= 5'h00;
    end else if (in_reset) begin
      expanded_bus  <= (mode_s == CRP_MODE_EXPANDED);
      bus_pin_count <= (mode_s == CRP_MODE_EXPANDED) ? 5'(`CRP_MUX_PINS) : 5'h00; // RL12
    end
  end
endmodule : crp_top

/* hdl/crp_map.svh */
// constants for the clock, reset and interrupt pin logic
`ifndef CRP_MAP_SVH
`define CRP_MAP_SVH
`define CRP_CLK_DIV       4
`define CRP_CLK_DIV_W     2
`define CRP_PH_RISE       2'h1
`define CRP_PH_FALL       2'h3
`define CRP_RST_STRETCH   4'hF
`define CRP_MUX_PINS      18
`endif

/* hdl/crp_pkg.sv */
// types for the clock, reset and interrupt pin logic
package crp_pkg;
  typedef enum logic [1:0] {
    CRP_MODE_SINGLE   = 2'h2,
    CRP_MODE_EXPANDED = 2'h3,
    CRP_MODE_BOOT     = 2'h0,
    CRP_MODE_TEST     = 2'h1
  } crp_mode_t;
  typedef enum logic [1:0] {
    CRP_RST_IDLE    = 2'h0,
    CRP_RST_DRIVE   = 2'h1,
    CRP_RST_RELEASE = 2'h2
  } crp_rst_state_t;
endpackage : crp_pkg

/* hdl/crp_sync.sv */
// two flip-flop synchroniser
`timescale 1ns/10ps
`include "crp_map.svh"
module crp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : crp_sync

/* bench/crp_far.sv */
// far side model: oscillator, pulled-up reset line, request sources
`timescale 1ns/10ps
module crp_far #(
  parameter int HALF = 77
) (
  input  wire logic ext_rst,
  input  wire logic irq_lo,
  input  wire logic nmi_lo,
  input  wire logic reset_pin_oe,
  output logic      osc_clock_in,
  output logic      reset_pin_in,
  output logic      int_req_n,
  output logic      nonmaskable_int_req_n
);
  initial begin
    osc_clock_in = 1'h0;
    #7;
    forever #(HALF) osc_clock_in = ~osc_clock_in;
  end
  assign #3 reset_pin_in = !(ext_rst || reset_pin_oe);
  assign #3 int_req_n = !irq_lo;
  assign #3 nonmaskable_int_req_n = !nmi_lo;
endmodule : crp_far

/* bench/crp_assertions.sv */
// checker for the pin front end
`timescale 1ns/10ps
module crp_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bus_clk,
  input wire logic data_phase,
  input wire logic internal_phase,
  input wire logic halt_req,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic core_reset_n,
  input wire logic clk_monitor_fail,
  input wire logic watchdog_timer_fail,
  input wire logic edge_sel,
  input wire logic nonmaskable_int_req_n,
  input wire logic nmi_mask,
  input wire logic nmi_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_phase_split: assert property (data_phase == bus_clk && internal_phase != bus_clk)
    else $error("phase");
  a_halt_stops: assert property (halt_req[*2] |-> !bus_clk) else $error("halt");
  a_fail_drives: assert property (watchdog_timer_fail || clk_monitor_fail |=> reset_pin_oe)
    else $error("fail");
  a_oe_core: assert property (reset_pin_oe |=> !core_reset_n) else $error("core");
  a_oe_hold: assert property ($rose(reset_pin_oe) |-> reset_pin_oe[*8]) else $error("hold");
  a_pin_init: assert property (!reset_pin_in[*5] |-> !edge_sel && nmi_mask)
    else $error("init");
  a_nmi_masked: assert property (nmi_mask && $past(nmi_mask) |-> !nmi_pending)
    else $error("mask");
  a_nmi_level: assert property ((!nmi_mask && !nonmaskable_int_req_n && core_reset_n)[*5]
    |-> nmi_pending) else $error("nmi");
  cover property ($rose(bus_clk));
  cover property (reset_pin_oe);
  cover property (nmi_pending);
endmodule : crp_assertions
bind crp_top crp_assertions crp_assertions_inst (.*);

/* bench/tb.sv */
// self-checking bench for the pin front end
`timescale 1ns/10ps
`include "crp_map.svh"
module tb;
  logic clk_sys = 1'h0, rst_n = 1'h0, halt_req = 1'h0, clk_monitor_fail = 1'h0;
  logic watchdog_timer_fail = 1'h0, edge_sel_wr = 1'h0, edge_sel_data = 1'h0, int_ack = 1'h0;
  logic nmi_mask_clear = 1'h0, ext_rst = 1'h0, irq_lo = 1'h0, nmi_lo = 1'h0, osc_q = 1'h0;
  logic [1:0] mode_straps = 2'h2;
  logic osc_clock_in, osc_drive_out, bus_clk, data_phase, internal_phase, reset_pin_in;
  logic reset_pin_out, reset_pin_oe, core_reset_n, int_req_n, edge_sel, int_pending;
  logic nonmaskable_int_req_n, nmi_mask, nmi_pending, expanded_bus;
  logic [4:0] bus_pin_count;
  int errors = 0, n_tests = 0, osc_n = 0;
  always #20 clk_sys = ~clk_sys;
  crp_top crp_top_inst (.*);
  crp_far crp_far_inst (.*);
  always @(posedge clk_sys) begin
    osc_q <= osc_clock_in;
    osc_n <= osc_n + int'(osc_clock_in && !osc_q);
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task chk(input logic [4:0] a, input logic [4:0] e, input string m);
    #1 n_tests++;
    if (a !== e) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task results;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task wb(input logic v);
    int k;
    for (k = 0; k < 99 && bus_clk !== v; k++) @(posedge clk_sys) #1;
    if (k == 99) begin
      errors++;
      results;
    end
  endtask : wb
  task t_clock;
    int a;
    wb(1'h0);
    wb(1'h1);
    a = osc_n;
    wb(1'h0);
    wb(1'h1);
    chk(5'(osc_n - a), 5'h04, "ratio");
    chk(data_phase, 1'h1, "phase");
    chk(internal_phase, 1'h0, "internal");
    chk(osc_drive_out, 1'h0, "drive");
    cyc(1);
    halt_req <= 1'h1;
    cyc(12);
    chk(bus_clk, 1'h0, "halt");
    cyc(1);
    halt_req <= 1'h0;
    $display("done clock");
  endtask : t_clock
  task t_fail;
    int i, k;
    for (i = 0; i < 2; i++) begin
      cyc(1);
      {clk_monitor_fail, watchdog_timer_fail} <= i ? 2'h1 : 2'h2;
      cyc(1);
      {clk_monitor_fail, watchdog_timer_fail} <= 2'h0;
      cyc(1);
      chk(reset_pin_oe, 1'h1, "oe");
      chk(core_reset_n, 1'h0, "core");
      chk(reset_pin_out, 1'h0, "low");
      for (k = 0; k < 60 && reset_pin_oe; k++) @(posedge clk_sys) #1;
      chk(k >= 15 && k < 60, 1'h1, "stretch");
      cyc(12);
      chk(core_reset_n, 1'h1, "back");
    end
    $display("done fail");
  endtask : t_fail
  task t_mode;
    int m;
    for (m = 0; m < 4; m++) begin
      cyc(1);
      edge_sel_wr <= 1'h1;
      edge_sel_data <= 1'h1;
      nmi_mask_clear <= 1'h1;
      mode_straps <= m[1:0];
      cyc(1);
      edge_sel_wr <= 1'h0;
      nmi_mask_clear <= 1'h0;
      ext_rst <= 1'h1;
      cyc(6);
      ext_rst <= 1'h0;
      cyc(8);
      chk(expanded_bus, m == 3, "mode");
      chk(bus_pin_count, (m == 3) ? 5'(`CRP_MUX_PINS) : 5'h00, "pins");
      chk(edge_sel, 1'h0, "sel");
      chk(nmi_mask, 1'h1, "mask");
    end
    $display("done mode");
  endtask : t_mode
  task t_irq;
    cyc(1);
    irq_lo <= 1'h1;
    cyc(6);
    chk(int_pending, 1'h1, "level");
    cyc(1);
    irq_lo <= 1'h0;
    cyc(4);
    chk(int_pending, 1'h0, "free");
    cyc(1);
    edge_sel_wr <= 1'h1;
    edge_sel_data <= 1'h1;
    cyc(1);
    edge_sel_wr <= 1'h0;
    cyc(6);
    chk(int_pending, 1'h0, "idle");
    cyc(1);
    irq_lo <= 1'h1;
    cyc(2);
    irq_lo <= 1'h0;
    cyc(6);
    chk(int_pending, 1'h1, "edge");
    cyc(1);
    int_ack <= 1'h1;
    cyc(1);
    int_ack <= 1'h0;
    cyc(2);
    chk(int_pending, 1'h0, "ack");
    $display("done irq");
  endtask : t_irq
  task t_nmi;
    cyc(1);
    nmi_lo <= 1'h1;
    cyc(6);
    chk(nmi_pending, 1'h0, "masked");
    cyc(1);
    nmi_mask_clear <= 1'h1;
    cyc(1);
    nmi_mask_clear <= 1'h0;
    cyc(6);
    chk(nmi_pending, 1'h1, "nmi");
    cyc(1);
    nmi_lo <= 1'h0;
    cyc(6);
    chk(nmi_pending, 1'h0, "off");
    $display("done nmi");
  endtask : t_nmi
  initial begin
    cyc(2);
    rst_n <= 1'h1;
    cyc(4);
    chk(nmi_mask, 1'h1, "start");
    t_clock;
    t_fail;
    t_mode;
    t_irq;
    t_nmi;
    results;
  end
  initial begin
    cyc(20000);
    errors++;
    results;
  end
endmodule : tb
